// [verilog/hci_status_defines.svh]
`ifndef HCI_STATUS_DEFINES_SVH
`define HCI_STATUS_DEFINES_SVH
// status and reason codes
`define ST_SUCCESS        8'h00
`define ST_UNKNOWN_CMD    8'h01
`define ST_NO_CONN        8'h02
`define ST_HW_FAIL        8'h03
`define ST_PAGE_TIMEOUT   8'h04
`define ST_AUTH_FAIL      8'h05
`define ST_KEY_MISSING    8'h06
`define ST_MEM_FULL       8'h07
`define ST_CONN_TIMEOUT   8'h08
`define ST_MAX_CONN       8'h09
`define ST_PAIR_DENIED    8'h18
`define ST_LM_UNKNOWN_MSG 8'h19
`define ST_REMOTE_FEAT    8'h1A
`define ST_LM_OFFSET_REJ  8'h1B
`define ST_LM_INTVL_REJ   8'h1C
`define ST_LM_AIR_REJ     8'h1D
`define ST_LM_BAD_PARAM   8'h1E
`define ST_UNSPECIFIED    8'h1F
`define ST_LM_GROUP_LO    8'h20
`define ST_LM_GROUP_HI    8'h24
`define ST_RESERVED_LO    8'h25
// parameter length of a bare status return
`define RET_LEN_STATUS    8'h01
// parameter length of a key store return: status and count
`define RET_LEN_KEYS      8'h02
`endif

// [verilog/hci_status_pkg.sv]
package hci_status_pkg;
	// event that carries a status or reason
	typedef enum logic [2:0] {
		EV_NONE        = 3'b000,
		EV_CMD_STATUS  = 3'b001,
		EV_CMD_COMPL   = 3'b010,
		EV_CONN_COMPL  = 3'b011,
		EV_AUTH_COMPL  = 3'b100,
		EV_DISC_COMPL  = 3'b101,
		EV_NAME_COMPL  = 3'b110
	} event_kind_t;
	// failure causes that can be raised
	typedef enum logic [3:0] {
		CAUSE_NONE         = 4'h0,
		CAUSE_UNKNOWN_CMD  = 4'h1,
		CAUSE_NO_CONN      = 4'h2,
		CAUSE_HW_FAIL      = 4'h3,
		CAUSE_PAGE_TIMEOUT = 4'h4,
		CAUSE_AUTH_FAIL    = 4'h5,
		CAUSE_KEY_MISSING  = 4'h6,
		CAUSE_MEM_FULL     = 4'h7,
		CAUSE_MAX_CONN     = 4'h9,
		CAUSE_PAIR_DENIED  = 4'hA,
		CAUSE_REMOTE_FEAT  = 4'hB,
		CAUSE_UNSPECIFIED  = 4'hC,
		CAUSE_LM_CODE      = 4'hD
	} cause_t;
	// command or procedure in flight
	typedef enum logic [2:0] {
		CMD_GENERIC   = 3'b000,
		CMD_CREATE    = 3'b001,
		CMD_ADD_VOICE = 3'b010,
		CMD_NAME_REQ  = 3'b011,
		CMD_AUTH      = 3'b100,
		CMD_STORE_KEY = 3'b101
	} cmd_kind_t;
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_STATUS = 2'b01,
		ST_FINAL  = 2'b10,
		ST_DISC   = 2'b11
	} fsm_t;
endpackage

// [verilog/hci_code_filter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hci_status_defines.svh"
// screens a code: reserved and link-manager-only values become unspecified
module hci_code_filter (
	// raw code
	input  wire logic [7:0] raw_code,
	// code safe for host events
	output var  logic [7:0] safe_code
);
	always_comb begin
		safe_code = raw_code;
		if (raw_code >= `ST_RESERVED_LO) begin
			safe_code = `ST_UNSPECIFIED;
		end else if (raw_code >= `ST_LM_UNKNOWN_MSG && raw_code <= `ST_LM_BAD_PARAM &&
		             raw_code != `ST_REMOTE_FEAT) begin
			safe_code = `ST_UNSPECIFIED;
		end
	end
endmodule // hci_code_filter
`default_nettype wire

// [verilog/hci_error_status_logic.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hci_status_defines.svh"
// Function
// - zero success, nonzero byte names failure
// - never emit codes 0x25 and above
// - fixed codes 0x18 0x1A 0x1F 0x20-0x24
// - link-manager-only codes never reach host
// - deferrable errors go in the completion event
// - unknown opcode returns 0x01
// - unknown opcode complete carries status only
// - missing connection returns 0x02
// - missing connection on complete-type uses status
// - hardware fault 0x03, complete-type uses complete
// - page timeout 0x04 in connection/name complete
// - wrong key or pin gives 0x05
// - missing pin gives 0x06
// - no storage gives 0x07 in complete
// - key store overflow: no error, report count
// - supervision timeout gives reason 0x08
// - one disconnection event per handle; a link loss seen while busy is not latched and gets no event
// - timeout during setup in connection complete
// - no more connections gives 0x09
// - name request may report 0x09
module hci_error_status_logic
#(
	parameter int HANDLE_W = 12,
	parameter int MAX_HANDLES = 4,
	parameter int KEY_CNT_W = 8
) (
	// clock and reset
	input  wire logic                             ref_clk,
	input  wire logic                             rst_n,
	// command outcome request
	input  wire logic                             req_valid,
	input  wire hci_status_pkg::cmd_kind_t        req_cmd,
	input  wire logic                             req_uses_complete,
	input  wire hci_status_pkg::cause_t           req_cause,
	input  wire logic [7:0]                       req_lm_code,
	input  wire logic                             req_in_setup,
	input  wire logic [KEY_CNT_W-1:0]             req_keys_asked,
	input  wire logic [KEY_CNT_W-1:0]             req_keys_free,
	// supervision timeout on a physical link
	input  wire logic                             link_lost,
	input  wire logic [MAX_HANDLES-1:0]           link_handles_used,
	input  wire logic [MAX_HANDLES*HANDLE_W-1:0]  link_handles,
	// event output
	output var  logic                             ev_valid,
	output var  hci_status_pkg::event_kind_t      ev_kind,
	output var  logic [7:0]                       ev_status,
	output var  logic [7:0]                       ev_ret_len,
	output var  logic [HANDLE_W-1:0]              ev_handle,
	output var  logic [KEY_CNT_W-1:0]             ev_keys_stored,
	output var  logic                             busy
);
	import hci_status_pkg::*;

	typedef struct packed {
		// sequencer and the deferred second event
		fsm_t                    fsm;
		event_kind_t             final_kind;
		logic [7:0]              final_code;
		// handles latched on a link loss, still to be reported
		logic [MAX_HANDLES-1:0]  pending;
		logic [MAX_HANDLES*HANDLE_W-1:0] handles;
		// registered event outputs
		logic                    ev_valid;
		event_kind_t             ev_kind;
		logic [7:0]              ev_status;
		logic [7:0]              ev_ret_len;
		logic [HANDLE_W-1:0]     ev_handle;
		logic [KEY_CNT_W-1:0]    ev_keys_stored;
		logic                    busy;
	} state_t;

	state_t st;
	state_t next_st;
	logic [7:0] raw_code;
	logic [7:0] safe_code;
	logic [MAX_HANDLES-1:0] first_hot;
	logic [HANDLE_W-1:0] first_handle;
	// completion event chosen from the command kind
	event_kind_t compl_kind;
	// cause reported in the completion event, not in command status
	logic deferred_cause;
	// link loss with live handles, which wins over a request
	logic loss_hit;
	// link keys that actually fit
	logic [KEY_CNT_W-1:0] keys_fit;
	// latched handles, one slot per entry
	wire logic [HANDLE_W-1:0] handle_arr [MAX_HANDLES];

	// cause to raw code
	always_comb begin
		raw_code = `ST_SUCCESS;
		unique case (req_cause)
			CAUSE_NONE:         raw_code = `ST_SUCCESS;
			CAUSE_UNKNOWN_CMD:  raw_code = `ST_UNKNOWN_CMD;
			CAUSE_NO_CONN:      raw_code = `ST_NO_CONN;
			CAUSE_HW_FAIL:      raw_code = `ST_HW_FAIL;
			CAUSE_PAGE_TIMEOUT: raw_code = `ST_PAGE_TIMEOUT;
			CAUSE_AUTH_FAIL:    raw_code = `ST_AUTH_FAIL;
			CAUSE_KEY_MISSING:  raw_code = `ST_KEY_MISSING;
			CAUSE_MEM_FULL:     raw_code = `ST_MEM_FULL;
			CAUSE_MAX_CONN:     raw_code = `ST_MAX_CONN;
			CAUSE_PAIR_DENIED:  raw_code = `ST_PAIR_DENIED;
			CAUSE_REMOTE_FEAT:  raw_code = `ST_REMOTE_FEAT;
			CAUSE_UNSPECIFIED:  raw_code = `ST_UNSPECIFIED;
			CAUSE_LM_CODE:      raw_code = req_lm_code;
			default:            raw_code = `ST_UNSPECIFIED;
		endcase
	end

	hci_code_filter u_filter (
		.raw_code  (raw_code),
		.safe_code (safe_code)
	);

	// unpack the latched handle word into slots
	for (genvar g = 0; g < MAX_HANDLES; g++) begin : g_slot
		assign handle_arr[g] = st.handles[g*HANDLE_W +: HANDLE_W];
	end

	// lowest pending handle; scanning downward lets the lowest index win
	always_comb begin
		first_hot = '0;
		first_handle = '0;
		for (int i = MAX_HANDLES - 1; i >= 0; i--) begin
			if (st.pending[i]) begin
				first_hot = '0;
				first_hot[i] = 1'b1;
				first_handle = handle_arr[i];
			end
		end
	end

	// completion event that follows a zero command status
	always_comb begin
		compl_kind = EV_CONN_COMPL;
		case (req_cmd)
			CMD_AUTH:     compl_kind = EV_AUTH_COMPL;
			CMD_NAME_REQ: compl_kind = EV_NAME_COMPL;
			default:      compl_kind = EV_CONN_COMPL;
		endcase
	end

	assign deferred_cause = (req_cause == CAUSE_PAGE_TIMEOUT) || (req_cause == CAUSE_AUTH_FAIL) ||
	                        (req_cause == CAUSE_KEY_MISSING) || (req_cause == CAUSE_PAIR_DENIED);

	assign keys_fit = (req_keys_asked > req_keys_free) ? req_keys_free : req_keys_asked;

	assign loss_hit = link_lost && (link_handles_used != '0);

	// next state; a request is only looked at while idle, so a pair is never split
	always_comb begin
		next_st = st;
		next_st.ev_valid = 1'b0;
		unique case (st.fsm)
			ST_IDLE: begin
				if (loss_hit) begin
					// latch every handle on the link
					next_st.pending = link_handles_used;
					next_st.handles = link_handles;
					next_st.fsm = ST_DISC;
					next_st.busy = 1'b1;
				end else if (req_valid) begin
					next_st.ev_valid = 1'b1;
					next_st.ev_ret_len = `RET_LEN_STATUS;
					next_st.ev_handle = '0;
					next_st.ev_keys_stored = '0;
					if (req_cmd == CMD_STORE_KEY) begin
						next_st.ev_kind = EV_CMD_COMPL;
						next_st.ev_status = `ST_SUCCESS;
						next_st.ev_keys_stored = keys_fit;
						next_st.ev_ret_len = `RET_LEN_KEYS;
					end else if (req_in_setup && req_cause == CAUSE_NONE && link_lost) begin
						next_st.ev_kind = EV_CONN_COMPL;
						next_st.ev_status = `ST_CONN_TIMEOUT;
					end else if (safe_code == `ST_SUCCESS) begin
						next_st.ev_status = `ST_SUCCESS;
						next_st.ev_kind = req_uses_complete ? EV_CMD_COMPL : EV_CMD_STATUS;
						if (!req_uses_complete) begin
							next_st.final_code = `ST_SUCCESS;
							next_st.final_kind = compl_kind;
							next_st.fsm = ST_FINAL;
							next_st.busy = 1'b1;
						end
					end else if (deferred_cause) begin
						// carried by the completion event after zero status
						next_st.ev_kind = EV_CMD_STATUS;
						next_st.ev_status = `ST_SUCCESS;
						next_st.final_code = safe_code;
						next_st.final_kind = compl_kind;
						next_st.fsm = ST_FINAL;
						next_st.busy = 1'b1;
					end else if (req_uses_complete && req_cause != CAUSE_NO_CONN) begin
						next_st.ev_kind = EV_CMD_COMPL;
						next_st.ev_status = safe_code;
					end else begin
						next_st.ev_kind = EV_CMD_STATUS;
						next_st.ev_status = safe_code;
					end
				end
			end
			ST_FINAL: begin
				// second event of a pair, then ready for the next request
				next_st.ev_valid = 1'b1;
				next_st.ev_kind = st.final_kind;
				next_st.ev_status = st.final_code;
				next_st.ev_ret_len = `RET_LEN_STATUS;
				next_st.fsm = ST_IDLE;
				next_st.busy = 1'b0;
			end
			ST_DISC: begin
				// one reason 0x08 event per handle
				next_st.ev_valid = 1'b1;
				next_st.ev_kind = EV_DISC_COMPL;
				next_st.ev_status = `ST_CONN_TIMEOUT;
				next_st.ev_ret_len = `RET_LEN_STATUS;
				next_st.ev_handle = first_handle;
				next_st.pending = st.pending & ~first_hot;
				if ((st.pending & ~first_hot) == '0) begin
					next_st.fsm = ST_IDLE;
					next_st.busy = 1'b0;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// event pulse, one cycle per event
	assign ev_valid       = st.ev_valid;
	// event fields, held until the next event
	assign ev_kind        = st.ev_kind;
	assign ev_status      = st.ev_status;
	assign ev_ret_len     = st.ev_ret_len;
	assign ev_handle      = st.ev_handle;
	assign ev_keys_stored = st.ev_keys_stored;
	// sequence in progress, requests ignored
	assign busy           = st.busy;
endmodule // hci_error_status_logic
`default_nettype wire

// [test/hci_status_checker_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// watches the status logic ports for code and event choices
module hci_status_checker
	import hci_status_pkg::*;
#(
	parameter int MAX_HANDLES = 4
) (
	input wire logic                    ref_clk,
	input wire logic                    rst_n,
	input wire logic                    req_valid,
	input wire hci_status_pkg::cause_t  req_cause,
	input wire logic                    req_uses_complete,
	input wire logic                    link_lost,
	input wire logic [MAX_HANDLES-1:0]  link_handles_used,
	input wire logic                    ev_valid,
	input wire hci_status_pkg::event_kind_t ev_kind,
	input wire logic [7:0]              ev_status,
	input wire logic [7:0]              ev_ret_len,
	input wire logic                    busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic take;
	// request accepted by an idle block
	assign take = req_valid && !busy && !link_lost;
	property p_reserved;
		ev_valid |-> ev_status < 8'h25;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code emitted");
	property p_lm_only;
		ev_valid |-> !(ev_status inside {8'h19, [8'h1B:8'h1E]});
	endproperty
	a_lm_only: assert property (p_lm_only) else $error("link-manager-only code emitted");
	property p_unknown;
		take && req_cause == CAUSE_UNKNOWN_CMD |=> ev_valid && ev_status == 8'h01;
	endproperty
	a_unknown: assert property (p_unknown) else $error("unknown opcode not reported");
	property p_ret_len;
		ev_valid && ev_kind == EV_CMD_COMPL && ev_status == 8'h01 |-> ev_ret_len == 8'h01;
	endproperty
	a_ret_len: assert property (p_ret_len) else $error("unknown opcode return too long");
	property p_no_conn;
		take && req_cause == CAUSE_NO_CONN |=> ev_valid && ev_kind == EV_CMD_STATUS && ev_status == 8'h02;
	endproperty
	a_no_conn: assert property (p_no_conn) else $error("missing connection misreported");
	property p_hw;
		take && req_cause == CAUSE_HW_FAIL && req_uses_complete |=>
			ev_valid && ev_kind == EV_CMD_COMPL && ev_status == 8'h03;
	endproperty
	a_hw: assert property (p_hw) else $error("hardware fault misreported");
	property p_page;
		take && req_cause == CAUSE_PAGE_TIMEOUT |=>
			ev_valid && ev_kind == EV_CMD_STATUS && ev_status == 8'h00 ##1 ev_valid && ev_status == 8'h04;
	endproperty
	a_page: assert property (p_page) else $error("page timeout sequence wrong");
	property p_reject;
		ev_valid && ev_kind == EV_CMD_STATUS && ev_status != 8'h00 |=> !ev_valid || $past(req_valid);
	endproperty
	a_reject: assert property (p_reject) else $error("event after rejection");
	property p_loss;
		link_lost && !busy && link_handles_used != '0 |->
			##2 ev_valid && ev_kind == EV_DISC_COMPL && ev_status == 8'h08;
	endproperty
	a_loss: assert property (p_loss) else $error("link loss not reported");
	property p_disc;
		ev_valid && ev_kind == EV_DISC_COMPL |-> ev_status == 8'h08;
	endproperty
	a_disc: assert property (p_disc) else $error("disconnection reason wrong");
	// main scenarios reached
	c_take: cover property (take);
	c_disc: cover property (ev_valid && ev_kind == EV_DISC_COMPL);
	c_compl: cover property (ev_valid && ev_kind == EV_CMD_COMPL);
	c_pair: cover property (ev_valid && ev_kind == EV_CMD_STATUS && ev_status == 8'h00 ##1 ev_valid);
endmodule // hci_status_checker
bind hci_error_status_logic hci_status_checker #(.MAX_HANDLES(MAX_HANDLES)) i_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.req_valid(req_valid), .req_cause(req_cause), .req_uses_complete(req_uses_complete), .link_lost(link_lost),
	.link_handles_used(link_handles_used), .ev_valid(ev_valid), .ev_kind(ev_kind), .ev_status(ev_status),
	.ev_ret_len(ev_ret_len), .busy(busy));
`default_nettype wire

// [test/hci_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// host side: logs every event it receives
module hci_host_model
	import hci_status_pkg::*;
(
	input wire logic        ref_clk,
	// event stream
	input wire logic        ev_valid,
	input wire event_kind_t ev_kind,
	input wire logic [7:0]  ev_status,
	input wire logic [7:0]  ev_ret_len,
	input wire logic [11:0] ev_handle,
	input wire logic [7:0]  ev_keys_stored
);
	int          n = 0;
	event_kind_t kd[64];
	logic [7:0]  st[64];
	logic [7:0]  rl[64];
	logic [11:0] hd[64];
	logic [7:0]  ks[64];
	// capture one record per event pulse
	always @(posedge ref_clk) begin
		if (ev_valid === 1'b1) begin
			kd[n] <= ev_kind;
			st[n] <= ev_status;
			rl[n] <= ev_ret_len;
			hd[n] <= ev_handle;
			ks[n] <= ev_keys_stored;
			n <= n + 1;
		end
	end
endmodule // hci_host_model
`default_nettype wire

// [test/tb_hci_error_status_logic.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_hci_error_status_logic;
	import hci_status_pkg::*;
	logic ref_clk = 0, rst_n = 0, req_valid = 0, req_uses_complete = 0, req_in_setup = 0, link_lost = 0;
	cmd_kind_t req_cmd = CMD_GENERIC;
	cause_t req_cause = CAUSE_NONE;
	logic [7:0] req_lm_code = 8'h00, req_keys_asked = 8'h00, req_keys_free = 8'h00;
	logic [3:0] link_handles_used = 4'h0;
	logic [47:0] link_handles = 48'h0;
	logic ev_valid, busy;
	event_kind_t ev_kind;
	logic [7:0] ev_status, ev_ret_len, ev_keys_stored;
	logic [11:0] ev_handle;
	int err_count = 0, tests_run = 0, b;
	hci_error_status_logic i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req_cmd(req_cmd),
		.req_uses_complete(req_uses_complete), .req_cause(req_cause), .req_lm_code(req_lm_code),
		.req_in_setup(req_in_setup), .req_keys_asked(req_keys_asked), .req_keys_free(req_keys_free),
		.link_lost(link_lost), .link_handles_used(link_handles_used), .link_handles(link_handles),
		.ev_valid(ev_valid), .ev_kind(ev_kind), .ev_status(ev_status), .ev_ret_len(ev_ret_len),
		.ev_handle(ev_handle), .ev_keys_stored(ev_keys_stored), .busy(busy));
	hci_host_model i_host (.ref_clk(ref_clk), .ev_valid(ev_valid), .ev_kind(ev_kind), .ev_status(ev_status),
		.ev_ret_len(ev_ret_len), .ev_handle(ev_handle), .ev_keys_stored(ev_keys_stored));
	// 200 MHz clock
	always #2.5 ref_clk = ~ref_clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one request pulse, then let both events land
	task automatic issue(input cmd_kind_t c, input logic uc, input cause_t ca, input logic [7:0] lm);
		b = i_host.n;
		@(posedge ref_clk) #1;
		req_cmd = c; req_uses_complete = uc; req_cause = ca; req_lm_code = lm; req_valid = 1;
		@(posedge ref_clk) #1 req_valid = 0;
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic seq(input cmd_kind_t c, input logic uc, input cause_t ca, input int n,
		input event_kind_t k0, input logic [7:0] s0, input event_kind_t k1, input logic [7:0] s1);
		issue(c, uc, ca, 8'h00);
		chk(i_host.n - b, n);
		chk(i_host.kd[b], k0);
		chk(i_host.st[b], s0);
		if (n > 1) begin
			chk(i_host.kd[b+1], k1);
			chk(i_host.st[b+1], s1);
		end
	endtask
	task automatic t_codes;
		seq(CMD_GENERIC, 1, CAUSE_UNKNOWN_CMD, 1, EV_CMD_COMPL, 8'h01, EV_NONE, 0);
		chk(i_host.rl[b], 8'h01);
		seq(CMD_GENERIC, 0, CAUSE_UNKNOWN_CMD, 1, EV_CMD_STATUS, 8'h01, EV_NONE, 0);
		seq(CMD_GENERIC, 1, CAUSE_NONE, 1, EV_CMD_COMPL, 8'h00, EV_NONE, 0);
		seq(CMD_GENERIC, 1, CAUSE_NO_CONN, 1, EV_CMD_STATUS, 8'h02, EV_NONE, 0);
		seq(CMD_GENERIC, 0, CAUSE_NO_CONN, 1, EV_CMD_STATUS, 8'h02, EV_NONE, 0);
		seq(CMD_GENERIC, 1, CAUSE_HW_FAIL, 1, EV_CMD_COMPL, 8'h03, EV_NONE, 0);
		seq(CMD_GENERIC, 0, CAUSE_HW_FAIL, 1, EV_CMD_STATUS, 8'h03, EV_NONE, 0);
		seq(CMD_GENERIC, 1, CAUSE_MEM_FULL, 1, EV_CMD_COMPL, 8'h07, EV_NONE, 0);
		seq(CMD_CREATE, 0, CAUSE_MAX_CONN, 1, EV_CMD_STATUS, 8'h09, EV_NONE, 0);
		seq(CMD_ADD_VOICE, 0, CAUSE_MAX_CONN, 1, EV_CMD_STATUS, 8'h09, EV_NONE, 0);
		seq(CMD_NAME_REQ, 0, CAUSE_MAX_CONN, 1, EV_CMD_STATUS, 8'h09, EV_NONE, 0);
		seq(CMD_GENERIC, 0, CAUSE_REMOTE_FEAT, 1, EV_CMD_STATUS, 8'h1A, EV_NONE, 0);
		seq(CMD_GENERIC, 0, CAUSE_UNSPECIFIED, 1, EV_CMD_STATUS, 8'h1F, EV_NONE, 0);
		seq(CMD_CREATE, 0, CAUSE_NONE, 2, EV_CMD_STATUS, 8'h00, EV_CONN_COMPL, 8'h00);
		seq(CMD_NAME_REQ, 0, CAUSE_NONE, 2, EV_CMD_STATUS, 8'h00, EV_NAME_COMPL, 8'h00);
		seq(CMD_CREATE, 0, CAUSE_PAGE_TIMEOUT, 2, EV_CMD_STATUS, 8'h00, EV_CONN_COMPL, 8'h04);
		seq(CMD_NAME_REQ, 0, CAUSE_PAGE_TIMEOUT, 2, EV_CMD_STATUS, 8'h00, EV_NAME_COMPL, 8'h04);
		seq(CMD_AUTH, 0, CAUSE_AUTH_FAIL, 2, EV_CMD_STATUS, 8'h00, EV_AUTH_COMPL, 8'h05);
		seq(CMD_CREATE, 0, CAUSE_KEY_MISSING, 2, EV_CMD_STATUS, 8'h00, EV_CONN_COMPL, 8'h06);
		seq(CMD_AUTH, 0, CAUSE_PAIR_DENIED, 2, EV_CMD_STATUS, 8'h00, EV_AUTH_COMPL, 8'h18);
	endtask
	// screened codes: link-manager group and 0x1A pass, the rest become unspecified
	task automatic t_lm;
		logic [7:0] lm[10] = '{8'h20, 8'h24, 8'h1A, 8'h19, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h25, 8'hFF};
		foreach (lm[i]) begin
			issue(CMD_GENERIC, 0, CAUSE_LM_CODE, lm[i]);
			chk(i_host.n - b, 1);
			chk(i_host.kd[b], EV_CMD_STATUS);
			chk(i_host.st[b], (i < 3) ? lm[i] : 8'h1F);
		end
	endtask
	task automatic t_keys;
		@(posedge ref_clk) #1;
		req_keys_asked = 8'h05;
		req_keys_free = 8'h03;
		seq(CMD_STORE_KEY, 1, CAUSE_NONE, 1, EV_CMD_COMPL, 8'h00, EV_NONE, 0);
		chk(i_host.ks[b], 8'h03);
		chk(i_host.rl[b], 8'h02);
		@(posedge ref_clk) #1;
		req_keys_asked = 8'h02;
		seq(CMD_STORE_KEY, 1, CAUSE_NONE, 1, EV_CMD_COMPL, 8'h00, EV_NONE, 0);
		chk(i_host.ks[b], 8'h02);
	endtask
	// two handles lost at once; a request then and while busy is dropped
	task automatic t_loss;
		b = i_host.n;
		@(posedge ref_clk) #1;
		link_handles = {12'h000, 12'h456, 12'h000, 12'h123};
		link_handles_used = 4'b0101;
		link_lost = 1;
		req_valid = 1;
		@(posedge ref_clk) #1;
		link_lost = 0;
		chk(busy, 1'b1);
		@(posedge ref_clk) #1;
		req_valid = 0;
		repeat (5) @(posedge ref_clk);
		#1;
		chk(busy, 1'b0);
		chk(i_host.n - b, 2);
		chk(i_host.kd[b], EV_DISC_COMPL);
		chk(i_host.kd[b+1], EV_DISC_COMPL);
		chk(i_host.st[b], 8'h08);
		chk(i_host.st[b+1], 8'h08);
		chk(i_host.hd[b], 12'h123);
		chk(i_host.hd[b+1], 12'h456);
		// loss seen while a connection is still being set up
		b = i_host.n;
		link_handles_used = 4'h0;
		link_lost = 1;
		req_valid = 1;
		req_in_setup = 1;
		req_cmd = CMD_CREATE;
		req_uses_complete = 0;
		req_cause = CAUSE_NONE;
		@(posedge ref_clk) #1;
		link_lost = 0;
		req_valid = 0;
		req_in_setup = 0;
		repeat (4) @(posedge ref_clk);
		chk(i_host.n - b, 1);
		chk(i_host.kd[b], EV_CONN_COMPL);
		chk(i_host.st[b], 8'h08);
	endtask
	task automatic print_verdict;
		$display("errors=%0d checks=%0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#20000;
		err_count++;
		print_verdict;
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		#1 rst_n = 1;
		t_codes;
		t_lm;
		t_keys;
		t_loss;
		print_verdict;
	end
endmodule // tb_hci_error_status_logic
`default_nettype wire
